/* File: verilog/scs_map.svh */
// scs_map.svh: timing counts and encodings for the card session sequencer
`ifndef SCS_MAP_SVH
`define SCS_MAP_SVH

`define SCS_CLK_HZ 20000000
`define SCS_PWRUP_US 1000
`define SCS_PWRUP_CYC ((`SCS_PWRUP_US * (`SCS_CLK_HZ / 1000000)))
`define SCS_PDN_HOLD_US 2000
`define SCS_PDN_HOLD_CYC ((`SCS_PDN_HOLD_US * (`SCS_CLK_HZ / 1000000)) + 1)
`define SCS_DEBOUNCE_US 5000
`define SCS_DEBOUNCE_CYC ((`SCS_DEBOUNCE_US * (`SCS_CLK_HZ / 1000000)))
`define SCS_STEP_CYC 8'h40
`define SCS_CNT_W 20
`define SCS_DIV_GND 2'h0
`define SCS_DIV_LOW 2'h1
`define SCS_DIV_HIGH 2'h2
`define SCS_DIV_VDD 2'h3

`endif

/* File: verilog/scs_pkg.sv */
// scs_pkg.sv: types for the card session sequencer
package scs_pkg;
  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ACT_VCC = 10'h002,
    ST_ACT_IO = 10'h004,
    ST_ACT_CLK = 10'h008,
    ST_WAIT_RST = 10'h010,
    ST_ACTIVE = 10'h020,
    ST_DEA_RST = 10'h040,
    ST_DEA_CLK = 10'h080,
    ST_DEA_IO = 10'h100,
    ST_DEA_VCC = 10'h200
  } scs_state_type;

  typedef enum logic [2:0] {
    DIR_NEUTRAL = 3'h1,
    DIR_CARD_IN = 3'h2,
    DIR_HOST_IN = 3'h4
  } scs_dir_type;
endpackage

/* File: verilog/scs_sequencer.sv */
// scs_sequencer.sv: smart card session sequencer with status line and data steering
`include "scs_map.svh"
`timescale 1ns/1ps
`default_nettype none

module scs_sequencer
  import scs_pkg::*;
#(
  parameter int PWRUP_CYC = `SCS_PWRUP_CYC,
  parameter int PDN_HOLD_CYC = `SCS_PDN_HOLD_CYC,
  parameter int DEBOUNCE_CYC = `SCS_DEBOUNCE_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_oscillator_input,
  input wire logic i_activation_command_n,
  input wire logic i_host_reset_in,
  input wire logic i_card_present_in,
  input wire logic i_card_voltage_select,
  input wire logic [1:0] i_card_clock_divide_select,
  input wire logic i_digital_supply_fault,
  input wire logic i_card_overcurrent,
  input wire logic i_card_supply_valid,
  input wire logic [2:0] i_card_data_in,
  output logic [2:0] o_card_data_out,
  output logic [2:0] o_card_data_oe,
  input wire logic [2:0] i_host_data_in,
  output logic [2:0] o_host_data_out,
  output logic [2:0] o_host_data_oe,
  output logic o_card_supply_en,
  output logic o_card_rst,
  output logic o_card_clk,
  output logic o_status_n,
  output logic o_power_down
);

  // ==========================================================
  // helpers
  function automatic logic cnt_done(input logic [`SCS_CNT_W-1:0] c, input int lim);
    cnt_done = (c >= lim[`SCS_CNT_W-1:0]);
  endfunction

  scs_state_type state_q;
  logic cmd_q, rst_in_q, card_present_in_q, osc_q;
  logic [`SCS_CNT_W-1:0] pwrup_cnt_q, pdn_cnt_q, deb_cnt_q, hold_cnt_q, settle_cnt_q;
  logic [7:0] step_cnt_q;
  logic supply_ok_q, card_present_in_ok_q, fault_q, vcc_fail_q, clk_run_q, io_rx_q;
  logic [1:0] div_sel_q;
  logic [2:0] div_cnt_q;
  logic cmd_fall, cmd_rise, rst_fall, in_session, hw_fault, step_done;

  assign cmd_fall = cmd_q && !i_activation_command_n;
  assign cmd_rise = !cmd_q && i_activation_command_n;
  assign rst_fall = rst_in_q && !i_host_reset_in;
  assign in_session = (state_q != ST_IDLE);
  assign step_done = (step_cnt_q == `SCS_STEP_CYC);
  assign hw_fault = i_card_overcurrent || i_digital_supply_fault || !i_card_present_in ||
                    (in_session && state_q != ST_ACT_VCC && !vcc_fail_q && !i_card_supply_valid &&
                     o_card_supply_en);

  // ==========================================================
  // input history
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      cmd_q <= 1'b1;
      rst_in_q <= 1'b0;
      card_present_in_q <= 1'b0;
      osc_q <= 1'b0;
    end else begin
      cmd_q <= i_activation_command_n;
      rst_in_q <= i_host_reset_in;
      card_present_in_q <= i_card_present_in;
      osc_q <= i_oscillator_input;
    end
  end

  // ==========================================================
  // supply power-up delay
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || i_digital_supply_fault) begin
      pwrup_cnt_q <= '0;
      supply_ok_q <= 1'b0;
    end else if (!supply_ok_q) begin
      pwrup_cnt_q <= pwrup_cnt_q + 1'b1;
      supply_ok_q <= cnt_done(pwrup_cnt_q + 1'b1, PWRUP_CYC);
    end
  end

  // ==========================================================
  // power-down entry and exit
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      pdn_cnt_q <= '0;
      o_power_down <= 1'b0;
      settle_cnt_q <= '0;
    end else begin
      if (o_power_down) begin
        pdn_cnt_q <= '0;
        if (!i_host_reset_in) begin
          o_power_down <= 1'b0;
          settle_cnt_q <= DEBOUNCE_CYC[`SCS_CNT_W-1:0];
        end
      end else if (!in_session && i_host_reset_in && i_activation_command_n && i_card_voltage_select) begin
        pdn_cnt_q <= pdn_cnt_q + 1'b1;
        if (cnt_done(pdn_cnt_q + 1'b1, PDN_HOLD_CYC)) begin
          o_power_down <= 1'b1;
        end
      end else begin
        pdn_cnt_q <= '0;
      end
      if (settle_cnt_q != '0) begin
        settle_cnt_q <= settle_cnt_q - 1'b1;
      end
    end
  end

  // ==========================================================
  // presence debounce and removal hold
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      deb_cnt_q <= '0;
      hold_cnt_q <= '0;
      card_present_in_ok_q <= 1'b0;
    end else begin
      if (!i_card_present_in) begin
        deb_cnt_q <= '0;
        card_present_in_ok_q <= 1'b0;
        if (card_present_in_q) begin
          hold_cnt_q <= DEBOUNCE_CYC[`SCS_CNT_W-1:0];
        end else if (hold_cnt_q != '0) begin
          hold_cnt_q <= hold_cnt_q - 1'b1;
        end
      end else begin
        if (hold_cnt_q != '0) begin
          hold_cnt_q <= hold_cnt_q - 1'b1;
        end
        if (!cnt_done(deb_cnt_q, DEBOUNCE_CYC)) begin
          deb_cnt_q <= deb_cnt_q + 1'b1;
        end else if (hold_cnt_q == '0) begin
          card_present_in_ok_q <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // session sequencer
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      state_q <= ST_IDLE;
      step_cnt_q <= 8'h00;
      o_card_supply_en <= 1'b0;
      clk_run_q <= 1'b0;
      io_rx_q <= 1'b0;
      o_card_rst <= 1'b0;
      fault_q <= 1'b0;
      vcc_fail_q <= 1'b0;
      div_sel_q <= `SCS_DIV_GND;
    end else begin
      step_cnt_q <= step_done ? 8'h00 : step_cnt_q + 8'h01;
      if (!i_activation_command_n && hw_fault && in_session) begin
        fault_q <= 1'b1;
      end else if (i_activation_command_n) begin
        fault_q <= 1'b0;
      end
      case (state_q)
        ST_IDLE: begin
          vcc_fail_q <= 1'b0;
          if (cmd_fall && supply_ok_q && i_card_present_in && !i_digital_supply_fault &&
              !o_power_down) begin
            state_q <= ST_ACT_VCC;
            step_cnt_q <= 8'h00;
            o_card_supply_en <= 1'b1;
            div_sel_q <= i_card_clock_divide_select;
          end
        end
        ST_ACT_VCC: begin
          if (i_activation_command_n || hw_fault) begin
            state_q <= ST_DEA_RST;
          end else if (step_done) begin
            if (!i_card_supply_valid) begin
              vcc_fail_q <= 1'b1;
              o_card_supply_en <= 1'b0;
              fault_q <= 1'b1;
              state_q <= ST_DEA_RST;
            end else if (i_host_reset_in) begin
              state_q <= ST_WAIT_RST;
            end else begin
              state_q <= ST_ACT_IO;
            end
          end
        end
        ST_ACT_IO: begin
          if (i_activation_command_n || hw_fault) begin
            state_q <= ST_DEA_RST;
          end else if (step_done) begin
            io_rx_q <= 1'b1;
            state_q <= ST_ACT_CLK;
          end
        end
        ST_ACT_CLK: begin
          if (i_activation_command_n || hw_fault) begin
            state_q <= ST_DEA_RST;
          end else if (step_done) begin
            clk_run_q <= 1'b1;
            state_q <= ST_ACTIVE;
          end
        end
        ST_WAIT_RST: begin
          io_rx_q <= 1'b1;
          if (i_activation_command_n || hw_fault) begin
            state_q <= ST_DEA_RST;
          end else if (rst_fall) begin
            clk_run_q <= 1'b1;
            state_q <= ST_ACTIVE;
          end
        end
        ST_ACTIVE: begin
          o_card_rst <= i_host_reset_in;
          if (i_activation_command_n || hw_fault) begin
            state_q <= ST_DEA_RST;
            step_cnt_q <= 8'h00;
          end
        end
        ST_DEA_RST: begin
          if (step_done) begin
            o_card_rst <= 1'b0;
            state_q <= ST_DEA_CLK;
          end
        end
        ST_DEA_CLK: begin
          if (step_done) begin
            clk_run_q <= 1'b0;
            state_q <= ST_DEA_IO;
          end
        end
        ST_DEA_IO: begin
          if (step_done) begin
            io_rx_q <= 1'b0;
            state_q <= ST_DEA_VCC;
          end
        end
        ST_DEA_VCC: begin
          if (step_done) begin
            o_card_supply_en <= 1'b0;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // status line
  always_ff @(posedge i_sys_clk) begin
    if (i_rst) begin
      o_status_n <= 1'b0;
    end else if (!i_activation_command_n && in_session) begin
      o_status_n <= !(fault_q || hw_fault);
    end else begin
      o_status_n <= card_present_in_ok_q && i_card_present_in && (hold_cnt_q == '0) && (settle_cnt_q == '0) &&
                    !fault_q && !vcc_fail_q;
    end
  end

  // ==========================================================
  // card clock divider, ratio frozen at activation
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !clk_run_q) begin
      div_cnt_q <= 3'h0;
      o_card_clk <= 1'b0;
    end else begin
      case (div_sel_q)
        `SCS_DIV_LOW: o_card_clk <= osc_q;
        `SCS_DIV_GND: o_card_clk <= div_cnt_q[1];
        `SCS_DIV_HIGH: o_card_clk <= div_cnt_q[2];
        default: o_card_clk <= div_cnt_q[0];
      endcase
      if (i_oscillator_input && !osc_q) begin
        div_cnt_q <= div_cnt_q + 3'h1;
      end
    end
  end

  // ==========================================================
  // data direction steering, one lane per contact pair
  scs_dir_type dir_q [3];
  logic [2:0] card_prev_q, host_prev_q;

  for (genvar g = 0; g < 3; g++) begin : g_lane
    always_ff @(posedge i_sys_clk) begin
      if (i_rst || !io_rx_q) begin
        dir_q[g] <= DIR_NEUTRAL;
        card_prev_q[g] <= 1'b1;
        host_prev_q[g] <= 1'b1;
      end else begin
        card_prev_q[g] <= i_card_data_in[g];
        host_prev_q[g] <= i_host_data_in[g];
        case (dir_q[g])
          DIR_NEUTRAL: begin
            if (host_prev_q[g] && !i_host_data_in[g]) begin
              dir_q[g] <= DIR_HOST_IN;
            end else if (card_prev_q[g] && !i_card_data_in[g]) begin
              dir_q[g] <= DIR_CARD_IN;
            end
          end
          DIR_HOST_IN: begin
            if (!host_prev_q[g] && i_host_data_in[g]) begin
              dir_q[g] <= DIR_NEUTRAL;
            end
          end
          DIR_CARD_IN: begin
            if (!card_prev_q[g] && i_card_data_in[g]) begin
              dir_q[g] <= DIR_NEUTRAL;
            end
          end
          default: begin
            dir_q[g] <= DIR_NEUTRAL;
          end
        endcase
      end
    end

    // outputs low on the card side until reception, neutral is released high
    always_comb begin
      o_card_data_out[g] = 1'b0;
      o_card_data_oe[g] = !io_rx_q || (dir_q[g] == DIR_HOST_IN);
      o_host_data_out[g] = 1'b0;
      o_host_data_oe[g] = io_rx_q && (dir_q[g] == DIR_CARD_IN);
    end
  end

endmodule

`default_nettype wire

/* File: sim/scs_sequencer_asserts.sv */
// scs_sequencer_asserts.sv: port-level property checker for the card session sequencer
`timescale 1ns/1ps
`default_nettype none
module scs_sequencer_asserts #(
  parameter int PWRUP_CYC = 20,
  parameter int PDN_HOLD_CYC = 40,
  parameter int DEBOUNCE_CYC = 50
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_oscillator_input,
  input wire logic i_activation_command_n,
  input wire logic i_host_reset_in,
  input wire logic i_card_present_in,
  input wire logic i_card_voltage_select,
  input wire logic [1:0] i_card_clock_divide_select,
  input wire logic i_digital_supply_fault,
  input wire logic i_card_overcurrent,
  input wire logic i_card_supply_valid,
  input wire logic [2:0] i_card_data_in,
  input wire logic [2:0] o_card_data_out,
  input wire logic [2:0] o_card_data_oe,
  input wire logic [2:0] i_host_data_in,
  input wire logic [2:0] o_host_data_out,
  input wire logic [2:0] o_host_data_oe,
  input wire logic o_card_supply_en,
  input wire logic o_card_rst,
  input wire logic o_card_clk,
  input wire logic o_status_n,
  input wire logic o_power_down
);
  // ==========
  // presence age, saturating
  logic [19:0] card_present_in_age_q;
  always_ff @(posedge i_sys_clk) begin
    if (i_rst || !i_card_present_in) card_present_in_age_q <= 20'h00000;
    else if (card_present_in_age_q != 20'hFFFFF) card_present_in_age_q <= card_present_in_age_q + 20'h00001;
  end
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  // ==========
  // properties
  sequence s_status_held_low;
    !o_status_n [*8];
  endsequence
  sequence s_fault_seen;
    i_card_overcurrent && o_card_supply_en && !i_activation_command_n;
  endsequence
  property p_act_start;
    $rose(o_card_supply_en) |-> !$past(i_activation_command_n) && $past(i_card_present_in)
      && !$past(i_digital_supply_fault) && !$past(o_power_down);
  endproperty
  property p_rst_copy;
    $rose(o_card_rst) |-> $past(i_host_reset_in) && o_card_supply_en;
  endproperty
  property p_clk_needs_supply;
    o_card_clk |-> o_card_supply_en;
  endproperty
  property p_dea_order;
    $fell(o_card_supply_en) |-> !o_card_rst && !o_card_clk && (o_card_data_oe == 3'h7);
  endproperty
  property p_removal;
    $fell(i_card_present_in) |=> s_status_held_low;
  endproperty
  property p_debounce;
    $rose(o_status_n) |-> card_present_in_age_q >= DEBOUNCE_CYC - 2;
  endproperty
  property p_overcurrent;
    i_card_overcurrent && o_card_supply_en |-> ##[1:270] !o_card_supply_en;
  endproperty
  property p_fault_flag;
    s_fault_seen |-> ##[1:3] !o_status_n;
  endproperty
  property p_reset_lines;
    $fell(i_rst) |-> (o_card_data_oe == 3'h7) && (o_host_data_oe == 3'h0);
  endproperty
  property p_steer;
    $rose(o_host_data_oe[0]) |-> !i_card_data_in[0];
  endproperty
  property p_pd_entry;
    $rose(o_power_down) |-> $past(i_host_reset_in) && $past(i_activation_command_n)
      && $past(i_card_voltage_select) && !o_card_supply_en;
  endproperty
  property p_pd_exit;
    $fell(o_power_down) |-> !$past(i_host_reset_in);
  endproperty
  a_act_start: assert property (p_act_start) else $error("supply rose without valid start");
  a_rst_copy: assert property (p_rst_copy) else $error("card rst rose without host reset");
  a_clk_needs_supply: assert property (p_clk_needs_supply) else $error("card clk without supply");
  a_dea_order: assert property (p_dea_order) else $error("supply off before rst clk io");
  a_removal: assert property (p_removal) else $error("status not held low on removal");
  a_debounce: assert property (p_debounce) else $error("status rose before debounce");
  a_overcurrent: assert property (p_overcurrent) else $error("no deactivation on overcurrent");
  a_fault_flag: assert property (p_fault_flag) else $error("fault not flagged on status");
  a_reset_lines: assert property (p_reset_lines) else $error("data lines wrong after reset");
  a_steer: assert property (p_steer) else $error("host driven without card falling");
  a_pd_entry: assert property (p_pd_entry) else $error("power-down entered wrongly");
  a_pd_exit: assert property (p_pd_exit) else $error("power-down left without reset low");
endmodule
bind scs_sequencer scs_sequencer_asserts #(.PWRUP_CYC(PWRUP_CYC), .PDN_HOLD_CYC(PDN_HOLD_CYC),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (
  .i_sys_clk(i_sys_clk),
  .i_rst(i_rst),
  .i_oscillator_input(i_oscillator_input),
  .i_activation_command_n(i_activation_command_n),
  .i_host_reset_in(i_host_reset_in),
  .i_card_present_in(i_card_present_in),
  .i_card_voltage_select(i_card_voltage_select),
  .i_card_clock_divide_select(i_card_clock_divide_select),
  .i_digital_supply_fault(i_digital_supply_fault),
  .i_card_overcurrent(i_card_overcurrent),
  .i_card_supply_valid(i_card_supply_valid),
  .i_card_data_in(i_card_data_in),
  .o_card_data_out(o_card_data_out),
  .o_card_data_oe(o_card_data_oe),
  .i_host_data_in(i_host_data_in),
  .o_host_data_out(o_host_data_out),
  .o_host_data_oe(o_host_data_oe),
  .o_card_supply_en(o_card_supply_en),
  .o_card_rst(o_card_rst),
  .o_card_clk(o_card_clk),
  .o_status_n(o_status_n),
  .o_power_down(o_power_down)
);
`default_nettype wire

/* File: sim/scs_host_model.sv */
// scs_host_model.sv: pulled-up data wires shared by sequencer, host and card
`timescale 1ns/1ps
`default_nettype none
module scs_host_model (
  input wire logic [2:0] i_dut_card_oe,
  input wire logic [2:0] i_dut_host_oe,
  input wire logic [2:0] i_card_pull,
  input wire logic [2:0] i_host_pull,
  output logic [2:0] o_card_wire,
  output logic [2:0] o_host_wire
);
  // open drain with pull-up: any party low wins
  assign o_card_wire = ~(i_dut_card_oe | i_card_pull);
  // the bench pulls the host side first and the card side after it, so pulls come from one side at a time
  assign o_host_wire = ~(i_dut_host_oe | i_host_pull);
endmodule
`default_nettype wire

/* File: sim/smart_card_session_sequencer_bench.sv */
// smart_card_session_sequencer_bench.sv: directed testbench for the card session sequencer
`timescale 1ns/1ps
`default_nettype none
module smart_card_session_sequencer_bench;
  import scs_pkg::*;
  logic clk, rst, osc, cmd_n, host_rst, present, vsel, sfault, oc, svalid;
  logic [1:0] div;
  logic [2:0] card_in, card_out, card_oe, host_in, host_out, host_oe, card_pull, host_pull;
  logic supply, card_rst, card_clk, status_n, pd;
  logic [2:0] r;
  int num_errors = 0;
  int num_checks = 0;
  scs_sequencer #(.PWRUP_CYC(20), .PDN_HOLD_CYC(40), .DEBOUNCE_CYC(50)) dut_u (
    .i_sys_clk(clk), .i_rst(rst), .i_oscillator_input(osc), .i_activation_command_n(cmd_n),
    .i_host_reset_in(host_rst), .i_card_present_in(present), .i_card_voltage_select(vsel),
    .i_card_clock_divide_select(div), .i_digital_supply_fault(sfault), .i_card_overcurrent(oc),
    .i_card_supply_valid(svalid), .i_card_data_in(card_in), .o_card_data_out(card_out),
    .o_card_data_oe(card_oe), .i_host_data_in(host_in), .o_host_data_out(host_out),
    .o_host_data_oe(host_oe), .o_card_supply_en(supply), .o_card_rst(card_rst),
    .o_card_clk(card_clk), .o_status_n(status_n), .o_power_down(pd));
  scs_host_model wires_u (.i_dut_card_oe(card_oe), .i_dut_host_oe(host_oe), .i_card_pull(card_pull),
    .i_host_pull(host_pull), .o_card_wire(card_in), .o_host_wire(host_in));
  always #25 clk = ~clk;
  always @(posedge clk) osc <= ~osc;
  // ==========
  // tasks
  task tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  task chk(input logic [2:0] got, input logic [2:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // counts card clock transitions over 12 system cycles, a divide by 2 of the toggling oscillator gives 6
  task clk_runs(output logic [2:0] ran);
    logic prev;
    ran = 3'h0;
    prev = card_clk;
    repeat (12) begin
      tick(1);
      if (card_clk !== prev) ran = ran + 3'h1;
      prev = card_clk;
    end
  endtask
  task end_test(input string name);
    $display("test %s ended, errors so far %0d", name, num_errors);
  endtask
  task finish_test;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    $display("watchdog expired at %0t", $time);
    finish_test;
  end
  // ==========
  // tests
  initial begin
    clk = 0; rst = 1; osc = 0; cmd_n = 1; host_rst = 0; present = 1; vsel = 0; div = 2'h3;
    sfault = 0; oc = 0; svalid = 1; card_pull = 3'h0; host_pull = 3'h0;
    tick(10);
    rst = 0;
    tick(1);
    chk(card_oe, 3'h7);
    chk(host_oe, 3'h0);
    chk(card_out | host_out, 3'h0);
    cmd_n = 0;
    tick(5);
    chk({2'h0, supply}, 3'h0);
    cmd_n = 1;
    tick(60);
    chk({2'h0, status_n}, 3'h1);
    end_test("power-up");
    cmd_n = 0;
    tick(3);
    chk({2'h0, supply}, 3'h1);
    tick(70);
    chk(card_oe, 3'h7);
    tick(70);
    chk(card_oe, 3'h0);
    tick(70);
    clk_runs(r);
    chk(r, 3'h6);
    host_rst = 1;
    tick(2);
    chk({2'h0, card_rst}, 3'h1);
    host_rst = 0;
    tick(2);
    chk({2'h0, card_rst}, 3'h0);
    host_pull = 3'h1;
    tick(2);
    chk(card_oe, 3'h1);
    chk(card_out | host_out, 3'h0);
    host_pull = 3'h0;
    tick(2);
    chk(card_oe, 3'h0);
    card_pull = 3'h5;
    tick(2);
    chk(host_oe, 3'h5);
    card_pull = 3'h0;
    tick(2);
    chk(host_oe, 3'h0);
    cmd_n = 1;
    tick(270);
    chk({supply, card_rst, card_clk}, 3'h0);
    chk(card_oe, 3'h7);
    end_test("activate");
    chk({2'h0, status_n}, 3'h1);
    present = 0;
    tick(1);
    chk({2'h0, status_n}, 3'h0);
    present = 1;
    tick(20);
    chk({2'h0, status_n}, 3'h0);
    tick(60);
    chk({2'h0, status_n}, 3'h1);
    end_test("removal");
    host_rst = 1;
    cmd_n = 0;
    tick(200);
    clk_runs(r);
    chk(r, 3'h0);
    host_rst = 0;
    tick(3);
    clk_runs(r);
    chk(r, 3'h6);
    oc = 1;
    tick(3);
    chk({2'h0, status_n}, 3'h0);
    tick(270);
    chk({2'h0, supply}, 3'h0);
    oc = 0;
    cmd_n = 1;
    tick(60);
    svalid = 0;
    cmd_n = 0;
    tick(72);
    chk({1'h0, supply, status_n}, 3'h0);
    svalid = 1;
    cmd_n = 1;
    // the fault deactivation runs four full steps before the session is over
    tick(270);
    end_test("faults");
    host_rst = 1;
    vsel = 1;
    tick(45);
    chk({2'h0, pd}, 3'h1);
    cmd_n = 0;
    vsel = 0;
    tick(3);
    chk({1'h0, pd, supply}, 3'h2);
    cmd_n = 1;
    host_rst = 0;
    tick(3);
    chk({1'h0, pd, status_n}, 3'h0);
    tick(60);
    chk({2'h0, status_n}, 3'h1);
    end_test("power-down");
    finish_test;
  end
endmodule
`default_nettype wire
